// [common/ccs_map.svh]
// offsets, index locations, field positions, codes and reset values of the bank
`ifndef CCS_MAP_SVH
`define CCS_MAP_SVH

// direct offsets from the board base address
`define CCS_OFS_BURST       16'h0405
`define CCS_OFS_FUNC        16'h0406
`define CCS_OFS_STATUS      16'h0407
// indexed window, present only while the bank is switched in
`define CCS_OFS_IDX_LSB     16'h000c
`define CCS_OFS_IDX_MSB     16'h000d
`define CCS_OFS_IDX_PTR     16'h000e

// locations inside the indexed array
`define CCS_IDX_GENCFG      8'h00
`define CCS_IDX_BURST       8'h41
`define CCS_IDX_FUNC        8'h42
`define CCS_IDX_STATUS      8'h43

// the only two defined codes of the enable registers
`define CCS_CODE_ON         8'h40
`define CCS_CODE_OFF        8'h00

// reset values
`define CCS_RST_BURST       1'b0
`define CCS_RST_FUNC        1'b0
`define CCS_RST_ADV_OFF     1'b0
`define CCS_RST_PTR         8'h00

// pointer steps
`define CCS_STEP_BYTE       8'h01
`define CCS_STEP_WORD       8'h02

// extended status fields
`define CCS_ST_BURST        6
`define CCS_ST_FUNC         5
`define CCS_ST_CONV         4
`define CCS_ST_WAIT         1
`define CCS_ST_CLK          0
// general configuration fields
`define CCS_GC_ADV_OFF      7

`endif

// [common/ccs_pkg.sv]
// types shared by the compatibility configuration bank
package ccs_pkg;

    // bus cycle phase, gray along idle -> read/write -> idle
    typedef enum logic [1:0]
    {
        CCS_IDLE  = 2'b00,
        CCS_READ  = 2'b01,
        CCS_WRITE = 2'b10
    } ccs_phase_e;

    // one captured bus cycle
    typedef struct packed
    {
        logic [15:0] addr;   // full i/o address
        logic [15:0] data;   // write data
        logic        sbhe_n; // high byte enable, low active
    } ccs_cycle_s;

    // sensed jumper field, ordered as it reads back
    typedef struct packed
    {
        logic clock_jumper_sense;
        logic dma_or_fifth_jumper_sense;
        logic mode_jumper_4_sense;
        logic mode_jumper_3_sense;
        logic mode_jumper_2_sense;
        logic mode_jumper_1_sense;
        logic mode_jumper_0_sense;
    } ccs_jumpers_s;

endpackage

// [core/ccs_index.sv]
// index pointer of the banked register array with automatic advance
`timescale 1ns/1ps
`include "ccs_map.svh"

module ccs_index (
    input  wire logic       clk_sys_i,   // system clock
    input  wire logic       rst_n_i,     // synchronous reset, low active
    input  wire logic       load_i,      // software writes the pointer
    input  wire logic [7:0] load_val_i,  // new pointer value
    input  wire logic       adv_i,       // one indexed data access ended
    input  wire logic       adv_word_i,  // that access was 16 bits
    input  wire logic       adv_off_i,   // automatic advance disabled
    output logic      [7:0] ptr_o        // current pointer
);

    // pointer: a load wins, else advance by access size unless held
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
            ptr_o <= `CCS_RST_PTR;
        else if (load_i)
            ptr_o <= load_val_i;
        else if (adv_i && !adv_off_i)
            ptr_o <= ptr_o + (adv_word_i ? `CCS_STEP_WORD : `CCS_STEP_BYTE);
    end

endmodule

// [core/ccs_regs.sv]
// compatibility configuration and status bank behind the i/o bus pins
`timescale 1ns/1ps
`include "ccs_map.svh"

module ccs_regs #(
    parameter logic [15:0] BASE_ADDR = 16'h0300 // board base i/o address
) (
    input  wire logic                  clk_sys_i,            // system clock, 10 MHz
    input  wire logic                  rst_n_i,              // synchronous reset, low active
    input  wire logic [15:0]           isa_addr_i,           // i/o address pins
    input  wire logic [15:0]           isa_data_i,           // data pins, inward
    output logic      [15:0]           isa_data_o,           // data pins, outward
    output logic                       isa_data_oe_o,        // drive data pins
    input  wire logic                  isa_ior_n_i,          // i/o read strobe
    input  wire logic                  isa_iow_n_i,          // i/o write strobe
    input  wire logic                  isa_sbhe_n_i,         // high byte enable
    input  wire logic                  isa_aen_i,            // dma owns the bus
    input  wire ccs_pkg::ccs_jumpers_s jumpers_i,            // jumper pins
    input  wire logic                  conversions_allowed_i, // adc triggers allowed
    input  wire logic                  bank_select_i,        // index window banked in
    input  wire logic                  ten_bit_decode_i,     // ten-bit address decode
    output logic                       burst_mode_on_o,      // adc burst mode enabled
    output logic                       ext_functions_on_o,   // extended functions enabled
    output logic                       index_advance_off_o,  // pointer advance held
    output logic      [7:0]            index_ptr_o           // index pointer value
);

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisation

    localparam int          BUS_W   = 36;                   // strobes, addr, data
    localparam logic [35:0] BUS_RST = {4'b1111, 32'h0000_0000}; // strobes idle

    logic [BUS_W-1:0]      bus_q;       // synchronised bus pins
    logic                  iow_n_q;     // synced write strobe
    logic                  ior_n_q;     // synced read strobe
    logic                  sbhe_n_q;    // synced byte enable
    logic                  aen_q;       // synced dma flag
    logic [15:0]           addr_q;      // synced address
    logic [15:0]           data_q;      // synced write data
    ccs_pkg::ccs_jumpers_s jmp_q;       // synced jumpers

    // bus pins through two stages
    ccs_sync #(
        .WIDTH   (BUS_W),
        .RST_VAL (BUS_RST)
    ) u_bus_sync (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .d_i       ({isa_aen_i, isa_sbhe_n_i, isa_ior_n_i, isa_iow_n_i,
                     isa_addr_i, isa_data_i}),
        .q_o       (bus_q)
    );

    // jumper pins through two stages
    ccs_sync #(
        .WIDTH   (7),
        .RST_VAL (7'h00)
    ) u_jmp_sync (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .d_i       (jumpers_i),
        .q_o       (jmp_q)
    );

    assign aen_q    = bus_q[35];
    assign sbhe_n_q = bus_q[34];
    assign ior_n_q  = bus_q[33];
    assign iow_n_q  = bus_q[32];
    assign addr_q   = bus_q[31:16];
    assign data_q   = bus_q[15:0];

    ////////////////////////////////////////////////////////////////////////////
    // state

    ccs_pkg::ccs_phase_e phase_r;    // current bus cycle phase
    ccs_pkg::ccs_cycle_s cyc_r;      // cycle held while the strobe is low
    logic                burst_r;    // burst mode enable
    logic                func_r;     // extended function enable
    logic                adv_off_r;  // index advance disable
    logic [7:0]          ptr;        // index pointer from the pointer block
    logic [15:0]         rd_data_r;  // read data driven to the pins
    logic                rd_hit_r;   // read address belongs to this bank

    ////////////////////////////////////////////////////////////////////////////
    // decode helpers

    // offset of an address from the base, cut to ten bits in ten-bit mode
    function automatic logic [15:0] ofs_of(input logic [15:0] a, input logic ten);
        logic [15:0] d;
        d = a - BASE_ADDR;
        ofs_of = ten ? {6'h00, d[9:0]} : d;
    endfunction

    // offset sits in the index window
    function automatic logic in_window(input logic [15:0] o);
        in_window = (o == `CCS_OFS_IDX_LSB) || (o == `CCS_OFS_IDX_MSB) ||
                    (o == `CCS_OFS_IDX_PTR);
    endfunction

    // apply a write code to an enable: only the two defined codes act
    function automatic logic apply_code(input logic cur, input logic [7:0] v);
        if (v == `CCS_CODE_ON)
            apply_code = 1'b1;
        else if (v == `CCS_CODE_OFF)
            apply_code = 1'b0;
        else
            apply_code = cur;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // read-back values

    logic [7:0] status_byte; // extended status
    logic [7:0] gencfg_byte; // general configuration

    always_comb
    begin
        status_byte                  = 8'h00;
        status_byte[`CCS_ST_BURST]   = burst_r;
        status_byte[`CCS_ST_FUNC]    = func_r;
        status_byte[`CCS_ST_CONV]    = conversions_allowed_i;
        status_byte[`CCS_ST_WAIT]    = 1'b0;
        status_byte[`CCS_ST_CLK]     = jmp_q.clock_jumper_sense;
    end

    assign gencfg_byte = {adv_off_r, jmp_q};

    // byte at an array location; write-only and absent ones read zero
    function automatic logic [7:0] idx_byte(input logic [7:0] i,
                                            input logic [7:0] st,
                                            input logic [7:0] gc);
        case (i)
            `CCS_IDX_GENCFG: idx_byte = gc;
            `CCS_IDX_STATUS: idx_byte = st;
            default:         idx_byte = 8'h00;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // current cycle decode

    logic [15:0] cur_ofs;    // offset of the held cycle
    logic        cur_word;   // held cycle is a 16-bit index data access
    logic        cur_win;    // held cycle hits the banked window
    logic [7:0]  cur_loc;    // array location of its low byte
    logic        end_write;  // write strobe just released
    logic        end_read;   // read strobe just released

    assign cur_ofs   = ofs_of(cyc_r.addr, ten_bit_decode_i);
    assign cur_win   = bank_select_i && in_window(cur_ofs);
    assign cur_word  = !cyc_r.sbhe_n && (cur_ofs == `CCS_OFS_IDX_LSB);
    assign cur_loc   = ptr + ((cur_ofs == `CCS_OFS_IDX_MSB) ? 8'h01 : 8'h00);
    assign end_write = (phase_r == ccs_pkg::CCS_WRITE) && iow_n_q;
    assign end_read  = (phase_r == ccs_pkg::CCS_READ) && ior_n_q;

    ////////////////////////////////////////////////////////////////////////////
    // bus cycle phase

    // follow the synced strobes; dma cycles are not ours
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
            phase_r <= ccs_pkg::CCS_IDLE;
        else
        begin
            case (phase_r)
                ccs_pkg::CCS_IDLE:
                begin
                    if (!aen_q && !ior_n_q)
                        phase_r <= ccs_pkg::CCS_READ;
                    else if (!aen_q && !iow_n_q)
                        phase_r <= ccs_pkg::CCS_WRITE;
                end
                ccs_pkg::CCS_READ:
                begin
                    if (ior_n_q)
                        phase_r <= ccs_pkg::CCS_IDLE;
                end
                ccs_pkg::CCS_WRITE:
                begin
                    if (iow_n_q)
                        phase_r <= ccs_pkg::CCS_IDLE;
                end
                default:
                    phase_r <= ccs_pkg::CCS_IDLE;
            endcase
        end
    end

    // hold address and data while a strobe is low, so the end uses stable values
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
            cyc_r <= '0;
        else if (!aen_q && (!ior_n_q || !iow_n_q))
        begin
            cyc_r.addr   <= addr_q;
            cyc_r.data   <= data_q;
            cyc_r.sbhe_n <= sbhe_n_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // write targets

    logic       wr_burst;   // write lands on the burst register
    logic       wr_func;    // write lands on the function register
    logic       wr_gencfg;  // write lands on general configuration
    logic [7:0] wr_burst_v; // byte for the burst register
    logic [7:0] wr_func_v;  // byte for the function register
    logic [7:0] wr_gc_v;    // byte for general configuration

    // direct offsets in full decode, array locations in the window
    always_comb
    begin
        wr_burst   = 1'b0;
        wr_func    = 1'b0;
        wr_gencfg  = 1'b0;
        wr_burst_v = cyc_r.data[7:0];
        wr_func_v  = cyc_r.data[7:0];
        wr_gc_v    = cyc_r.data[7:0];
        if (end_write)
        begin
            if (!ten_bit_decode_i && cur_ofs == `CCS_OFS_BURST)
                wr_burst = 1'b1;
            else if (!ten_bit_decode_i && cur_ofs == `CCS_OFS_FUNC)
                wr_func = 1'b1;
            else if (cur_win && cur_ofs != `CCS_OFS_IDX_PTR)
            begin
                // low byte, or the single byte of a byte access
                if (cur_loc == `CCS_IDX_BURST)
                    wr_burst = 1'b1;
                else if (cur_loc == `CCS_IDX_FUNC)
                    wr_func = 1'b1;
                else if (cur_loc == `CCS_IDX_GENCFG)
                    wr_gencfg = 1'b1;
                // high byte of a word lands one location up
                if (cur_word && (cur_loc + 8'h01) == `CCS_IDX_FUNC)
                begin
                    wr_func   = 1'b1;
                    wr_func_v = cyc_r.data[15:8];
                end
                else if (cur_word && (cur_loc + 8'h01) == `CCS_IDX_BURST)
                begin
                    wr_burst   = 1'b1;
                    wr_burst_v = cyc_r.data[15:8];
                end
                else if (cur_word && (cur_loc + 8'h01) == `CCS_IDX_GENCFG)
                begin
                    wr_gencfg = 1'b1;
                    wr_gc_v   = cyc_r.data[15:8];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // enable registers

    // function enable
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
            func_r <= `CCS_RST_FUNC;
        else if (wr_func)
            func_r <= apply_code(func_r, wr_func_v);
    end

    // burst enable, programmable only while functions are on
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
            burst_r <= `CCS_RST_BURST;
        else if (wr_burst && func_r)
            burst_r <= apply_code(burst_r, wr_burst_v);
    end

    // general configuration: only the advance disable bit is writable
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
            adv_off_r <= `CCS_RST_ADV_OFF;
        else if (wr_gencfg)
            adv_off_r <= wr_gc_v[`CCS_GC_ADV_OFF];
    end

    ////////////////////////////////////////////////////////////////////////////
    // index pointer

    logic ptr_load; // pointer written
    logic ptr_adv;  // index data access finished

    assign ptr_load = end_write && cur_win && (cur_ofs == `CCS_OFS_IDX_PTR);
    assign ptr_adv  = (end_write || end_read) && cur_win && (cur_ofs != `CCS_OFS_IDX_PTR);

    ccs_index u_index (
        .clk_sys_i  (clk_sys_i),
        .rst_n_i    (rst_n_i),
        .load_i     (ptr_load),
        .load_val_i (cyc_r.data[7:0]),
        .adv_i      (ptr_adv),
        .adv_word_i (cur_word),
        .adv_off_i  (adv_off_r),
        .ptr_o      (ptr)
    );

    ////////////////////////////////////////////////////////////////////////////
    // read path

    // refresh read data each cycle of a read; write-only registers do not answer at their direct offsets
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            rd_data_r <= 16'h0000;
            rd_hit_r  <= 1'b0;
        end
        else if (phase_r == ccs_pkg::CCS_READ && !ior_n_q)
        begin
            rd_hit_r  <= 1'b0;
            rd_data_r <= 16'h0000;
            if (!ten_bit_decode_i && cur_ofs == `CCS_OFS_STATUS)
            begin
                rd_hit_r  <= 1'b1;
                rd_data_r <= {8'h00, status_byte};
            end
            else if (cur_win && cur_ofs == `CCS_OFS_IDX_PTR)
            begin
                rd_hit_r  <= 1'b1;
                rd_data_r <= {8'h00, ptr};
            end
            else if (cur_win)
            begin
                rd_hit_r  <= 1'b1;
                rd_data_r <= {cur_word ? idx_byte(cur_loc + 8'h01, status_byte, gencfg_byte)
                                       : 8'h00,
                              idx_byte(cur_loc, status_byte, gencfg_byte)};
            end
        end
        else
            rd_hit_r <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign isa_data_o          = rd_data_r;
    assign isa_data_oe_o       = rd_hit_r && (phase_r == ccs_pkg::CCS_READ) && !ior_n_q;
    assign burst_mode_on_o     = burst_r;
    assign ext_functions_on_o  = func_r;
    assign index_advance_off_o = adv_off_r;
    assign index_ptr_o         = ptr;

endmodule

// [core/ccs_sync.sv]
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps

module ccs_sync #(
    parameter int               WIDTH   = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input  wire logic             clk_sys_i, // system clock
    input  wire logic             rst_n_i,   // synchronous reset, low active
    input  wire logic [WIDTH-1:0] d_i,       // asynchronous pins
    output logic      [WIDTH-1:0] q_o        // synchronised copy
);

    logic [WIDTH-1:0] meta_r; // first stage, read only by the second

    // two stages, reset to the idle pin levels
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            meta_r <= RST_VAL;
            q_o    <= RST_VAL;
        end
        else
        begin
            meta_r <= d_i;
            q_o    <= meta_r;
        end
    end

endmodule

// [test/ccs_host_model.sv]
// host cpu model that runs single i/o cycles on the bank pins
`timescale 1ns/1ps

module ccs_host_model (
    input  wire logic        clk_sys_i, // system clock
    output logic      [15:0] addr_o,    // address pins
    output logic      [15:0] data_o,    // write data pins
    output logic             ior_n_o,   // read strobe
    output logic             iow_n_o,   // write strobe
    output logic             sbhe_n_o   // high byte enable
);
    // idle bus at time zero
    initial
    begin
        addr_o   = 16'h0000;
        data_o   = 16'h0000;
        ior_n_o  = 1'b1;
        iow_n_o  = 1'b1;
        sbhe_n_o = 1'b1;
    end

    ////////////////////////////////////////////////////////////////
    // one cycle: strobe held 7+slow edges, then 6 quiet edges;
    // released pins show the inverse so stale values cannot pass
    task cyc(input logic [15:0] a, input logic [15:0] d, input logic rd,
             input logic word, input int slow);
        @(posedge clk_sys_i);
        addr_o   <= a;
        data_o   <= d;
        sbhe_n_o <= !word;
        ior_n_o  <= !rd;
        iow_n_o  <= rd;
        repeat (7 + slow) @(posedge clk_sys_i);
        ior_n_o  <= 1'b1;
        iow_n_o  <= 1'b1;
        addr_o   <= ~a;
        data_o   <= ~d;
        sbhe_n_o <= 1'b1;
        repeat (6) @(posedge clk_sys_i);
    endtask
endmodule

// [test/ccs_regs_properties.sv]
// concurrent checks on the pins of the configuration bank
`timescale 1ns/1ps
`include "ccs_map.svh"

module ccs_regs_checker #(
    parameter logic [15:0] BASE_ADDR = 16'h0300 // board base address
) (
    input wire logic        clk_sys_i,           // system clock
    input wire logic        rst_n_i,             // reset, low active
    input wire logic [15:0] isa_addr_i,          // address pins
    input wire logic [15:0] isa_data_o,          // read data
    input wire logic        isa_data_oe_o,       // data drive
    input wire logic        isa_ior_n_i,         // read strobe
    input wire logic        isa_iow_n_i,         // write strobe
    input wire logic        bank_select_i,       // window banked in
    input wire logic        ten_bit_decode_i,    // ten-bit decode
    input wire logic        burst_mode_on_o,     // burst enable
    input wire logic        ext_functions_on_o,  // functions enable
    input wire logic        index_advance_off_o, // advance held
    input wire logic [7:0]  index_ptr_o          // index pointer
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);

    property p_rst_clear;
        $rose(rst_n_i) |-> !burst_mode_on_o && !ext_functions_on_o
            && !index_advance_off_o && index_ptr_o == 8'h00;
    endproperty
    a_rst_clear: assert property (p_rst_clear) else $error("state not cleared");
    property p_burst_needs_ext;
        $rose(burst_mode_on_o) |-> $past(ext_functions_on_o);
    endproperty
    a_burst_needs_ext: assert property (p_burst_needs_ext) else $error("burst w/o ext");
    property p_ext_after_write;
        $changed(ext_functions_on_o) |-> $past(isa_iow_n_i) && $past(isa_iow_n_i, 2);
    endproperty
    a_ext_after_write: assert property (p_ext_after_write) else $error("ext moved early");
    property p_burst_after_write;
        $changed(burst_mode_on_o) |-> $past(isa_iow_n_i, 2) && $stable(ext_functions_on_o);
    endproperty
    a_burst_after_write: assert property (p_burst_after_write) else $error("burst moved");
    property p_oe_needs_ior;
        isa_data_oe_o |-> !$past(isa_ior_n_i, 2) || !$past(isa_ior_n_i, 3);
    endproperty
    a_oe_needs_ior: assert property (p_oe_needs_ior) else $error("drive without read");
    property p_status_bits;
        isa_data_oe_o && isa_addr_i == BASE_ADDR + `CCS_OFS_STATUS && !ten_bit_decode_i
            |-> isa_data_o[7:5] == {1'b0, burst_mode_on_o, ext_functions_on_o}
            && isa_data_o[3:1] == 3'b000;
    endproperty
    a_status_bits: assert property (p_status_bits) else $error("status bits wrong");
    property p_wo_silent;
        isa_data_oe_o |-> isa_addr_i != BASE_ADDR + `CCS_OFS_BURST
            && isa_addr_i != BASE_ADDR + `CCS_OFS_FUNC;
    endproperty
    a_wo_silent: assert property (p_wo_silent) else $error("write-only read back");
    property p_window_closed;
        isa_data_oe_o && !bank_select_i |-> isa_addr_i != BASE_ADDR + `CCS_OFS_IDX_LSB;
    endproperty
    a_window_closed: assert property (p_window_closed) else $error("window open");

    c_burst_on: cover property ($rose(burst_mode_on_o));
    c_status: cover property (isa_data_oe_o && isa_addr_i == BASE_ADDR + `CCS_OFS_STATUS);
    c_word_step: cover property (index_ptr_o == $past(index_ptr_o) + 8'h02);
endmodule

bind ccs_regs ccs_regs_checker #(.BASE_ADDR(BASE_ADDR)) u_chk (.clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i), .isa_addr_i(isa_addr_i), .isa_data_o(isa_data_o),
    .isa_data_oe_o(isa_data_oe_o), .isa_ior_n_i(isa_ior_n_i), .isa_iow_n_i(isa_iow_n_i),
    .bank_select_i(bank_select_i), .ten_bit_decode_i(ten_bit_decode_i),
    .burst_mode_on_o(burst_mode_on_o), .ext_functions_on_o(ext_functions_on_o),
    .index_advance_off_o(index_advance_off_o), .index_ptr_o(index_ptr_o));

// [test/tb_ccs_regs.sv]
// self-checking bench for the compatibility configuration bank
`timescale 1ns/1ps
`include "ccs_map.svh"

module tb_ccs_regs;
    localparam logic [15:0] BASE = 16'h0300; // board base address
    logic [15:0] addr, wdata, rdata, exp_q[$], msk_q[$]; // pins and expected reads
    logic ior_n, iow_n, sbhe_n, oe, oe_q = 1'b0, conv, bank, ten, burst, ext, adv; // levels
    logic clk_sys_i, rst_n_i, aen = 1'b0; // clock, reset, dma flag
    logic [7:0] ptr, code;     // pointer, undefined code
    ccs_pkg::ccs_jumpers_s jmp; // jumper pins
    int n_errors, samples_checked, seed, i; // counters

    ccs_host_model host (.clk_sys_i(clk_sys_i), .addr_o(addr), .data_o(wdata),
        .ior_n_o(ior_n), .iow_n_o(iow_n), .sbhe_n_o(sbhe_n));
    ccs_regs #(.BASE_ADDR(BASE)) uut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
        .isa_addr_i(addr), .isa_data_i(wdata), .isa_data_o(rdata), .isa_data_oe_o(oe),
        .isa_ior_n_i(ior_n), .isa_iow_n_i(iow_n), .isa_sbhe_n_i(sbhe_n), .isa_aen_i(aen),
        .jumpers_i(jmp), .conversions_allowed_i(conv), .bank_select_i(bank),
        .ten_bit_decode_i(ten), .burst_mode_on_o(burst), .ext_functions_on_o(ext),
        .index_advance_off_o(adv), .index_ptr_o(ptr));
    ////////////////////////////////////////////////////////////////
    // compares, driver tasks and the closing task
    task chk_lvl(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task chk_rd(input logic [15:0] got, input logic [15:0] exp, input logic [15:0] msk);
        chk_lvl(got & msk, exp & msk);
    endtask
    task wr(input logic [15:0] a, input logic [15:0] d);
        host.cyc(a, d, 1'b0, 1'b0, 0);
    endtask
    // note the expected read, then run it at a random pace
    task rd(input logic [15:0] a, input logic w, input logic [15:0] e, input logic [15:0] m);
        exp_q.push_back(e);
        msk_q.push_back(m);
        host.cyc(a, 16'h0000, 1'b1, w, $unsigned($random(seed)) % 3);
    endtask
    function logic [15:0] st(input logic b, input logic e, input logic c);
        st = {8'h00, 1'b0, b, e, c, 3'b000, jmp.clock_jumper_sense};
    endfunction
    task done(input string name);
        $display("test %0s done", name);
    endtask
    task summarize;
        chk_lvl(16'(exp_q.size()), 16'h0000);
        $display("checked %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // clock
    initial
    begin
        clk_sys_i = 1'b0;
        forever #50 clk_sys_i = ~clk_sys_i;
    end
    // watchdog well past the expected run
    initial
    begin
        #(6000 * 100);
        n_errors++;
        summarize;
    end
    // read monitor: first drive cycle takes the oldest note
    always @(posedge clk_sys_i)
    begin
        oe_q <= oe;
        if (oe === 1'b1 && oe_q !== 1'b1)
            if (exp_q.size() == 0)
                chk_lvl({15'h0000, oe}, 16'h0000);
            else
                chk_rd(rdata, exp_q.pop_front(), msk_q.pop_front());
    end

    ////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        seed = 45405;
        n_errors = 0;
        samples_checked = 0;
        rst_n_i = 1'b0;
        conv = 1'b1;
        bank = 1'b0;
        ten = 1'b0;
        jmp = 7'($random(seed));
        repeat (20) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        chk_lvl({5'h00, burst, ext, adv, ptr}, 16'h0000);
        rd(BASE + `CCS_OFS_STATUS, 1'b0, st(1'b0, 1'b0, 1'b1), 16'h00ff);
        done("reset");
        wr(BASE + `CCS_OFS_BURST, 16'h0040);
        chk_lvl({15'h0000, burst}, 16'h0000);
        wr(BASE + `CCS_OFS_FUNC, 16'h0040);
        chk_lvl({15'h0000, ext}, 16'h0001);
        wr(BASE + `CCS_OFS_BURST, 16'h0040);
        for (i = 0; i < 4; i++)
        begin
            code = 8'($random(seed)) | 8'h01;
            wr(BASE + ((i % 2) ? `CCS_OFS_FUNC : `CCS_OFS_BURST), {8'h00, code});
            chk_lvl({14'h0000, burst, ext}, 16'h0003);
        end
        conv <= 1'b0;
        rd(BASE + `CCS_OFS_STATUS, 1'b0, st(1'b1, 1'b1, 1'b0), 16'h00ff);
        host.cyc(BASE + `CCS_OFS_BURST, 16'h0000, 1'b1, 1'b0, 0);
        aen <= 1'b1;
        host.cyc(BASE + `CCS_OFS_STATUS, 16'h0000, 1'b1, 1'b0, 0);
        aen <= 1'b0;
        done("enables");
        bank <= 1'b1;
        wr(BASE + `CCS_OFS_IDX_PTR, 16'h0041);
        wr(BASE + `CCS_OFS_IDX_LSB, 16'h0000);
        chk_lvl({7'h00, burst, ptr}, 16'h0042);
        rd(BASE + `CCS_OFS_IDX_LSB, 1'b1, st(1'b0, 1'b1, 1'b0) << 8, 16'hff00);
        chk_lvl({8'h00, ptr}, 16'h0044);
        wr(BASE + `CCS_OFS_IDX_PTR, 16'h0000);
        rd(BASE + `CCS_OFS_IDX_LSB, 1'b0, {8'h00, 1'b0, jmp}, 16'h00ff);
        wr(BASE + `CCS_OFS_IDX_PTR, 16'h0000);
        wr(BASE + `CCS_OFS_IDX_LSB, 16'h0080);
        wr(BASE + `CCS_OFS_IDX_PTR, 16'h0000);
        rd(BASE + `CCS_OFS_IDX_LSB, 1'b0, {8'h00, 1'b1, jmp}, 16'h00ff);
        chk_lvl({7'h00, adv, ptr}, 16'h0100);
        done("window");
        ten <= 1'b1;
        wr(BASE + `CCS_OFS_FUNC, 16'h0000);
        chk_lvl({15'h0000, ext}, 16'h0001);
        wr(BASE + `CCS_OFS_IDX_PTR, 16'h0042);
        wr(BASE + `CCS_OFS_IDX_LSB, 16'h0000);
        chk_lvl({15'h0000, ext}, 16'h0000);
        ten <= 1'b0;
        bank <= 1'b0;
        host.cyc(BASE + `CCS_OFS_IDX_LSB, 16'h0000, 1'b1, 1'b0, 0);
        wr(BASE + `CCS_OFS_FUNC, 16'h0040);
        rst_n_i <= 1'b0;
        repeat (3) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        chk_lvl({7'h00, ext, ptr}, 16'h0000);
        done("ten-bit and reset");
        summarize;
    end
endmodule
